// ### rtl/watchdog_reset_supervisor.sv
// watchdog, power-fail reset, chip-select gating and early warning logic
// assumes comparator and float-detect results arrive as asynchronous levels
`include "wd_supervisor_regs.svh"
module watchdog_reset_supervisor (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic watchdog_toggle_in,
  input  wire logic toggle_floating,
  input  wire logic timebase_select,
  input  wire logic timebase_in,
  input  wire logic line_sense,
  input  wire logic early_warn_in,
  input  wire logic battery_backup,
  input  wire logic cs_in_n,
  output logic      cpu_reset_n,
  output logic      cpu_reset,
  output logic      undervoltage_n,
  output logic      backup_active,
  output logic      watchdog_expired_n,
  output logic      early_warn_n,
  output logic      cs_out_n
);
  import wd_supervisor_pkg::*;

  sup_s r;
  sup_s next_r;

  // period for a state; ext mode also covers the capacitor oscillator
  function automatic tick_t period_of(input logic ext, input logic per_hi,
                                      input wd_state_e st);
    tick_t p;
    p = ext ? tick_t'(`EXT_NORMAL_TKS) : tick_t'(`INT_SHORT_TKS);
    case (st)
      st_reset: p = ext ? tick_t'(`EXT_RESET_TKS) : tick_t'(`INT_RESET_TKS);
      st_long:  p = ext ? tick_t'(`EXT_LONG_TKS) : tick_t'(`INT_LONG_TKS);
      st_short: begin
        if (!ext && per_hi) begin
          p = tick_t'(`INT_LONG_TKS);
        end
      end
      default:  p = tick_t'(`INT_LONG_TKS);
    endcase
    return p;
  endfunction : period_of

  logic      ext;
  logic      tick;
  logic      edge_seen;
  logic      line_ok;
  logic      bk;
  tick_t     limit;

  always_comb begin
    next_r = r;
    // first stages feed only the second stages
    next_r.tb_sync    = {r.tb_sync[0], timebase_in};
    next_r.sel_sync   = {r.sel_sync[0], timebase_select};
    next_r.per_sync   = {r.per_sync[0], timebase_in};
    next_r.float_sync = {r.float_sync[0], toggle_floating};
    next_r.line_sync  = {r.line_sync[0], line_sense};
    next_r.warn_sync  = {r.warn_sync[0], early_warn_in};
    next_r.bk_sync    = {r.bk_sync[0], battery_backup};
    next_r.tog_pin    = {r.tog_pin[0], watchdog_toggle_in};
    next_r.cs_sync    = {r.cs_sync[0], cs_in_n};
    bk      = r.bk_sync[1];
    line_ok = r.line_sync[1];
    ext     = !r.sel_sync[1] && !bk;
    // internal 10.24 kHz timebase from the system clock
    if (r.osc_div == div_t'(`OSC_DIV - 1)) begin
      next_r.osc_div = '0;
      next_r.osc_clk = !r.osc_clk;
    end else begin
      next_r.osc_div = r.osc_div + div_t'(1);
    end
    next_r.tb_prev  = r.tb_sync[1];
    next_r.osc_prev = r.osc_clk;
    tick = ext ? (r.tb_sync[1] && !r.tb_prev) : (r.osc_clk && !r.osc_prev);
    // toggle sampled on timebase ticks so each edge counts once
    next_r.tog_sync = r.tog_sync;
    edge_seen = 1'b0;
    if (tick && !bk) begin
      next_r.tog_sync = {r.tog_sync[0], r.tog_pin[1]};
      edge_seen = (r.tog_sync[1] != r.tog_sync[0]) && !r.float_sync[1];
    end
    limit = period_of(ext, r.per_sync[1], r.state);
    if (!line_ok || bk) begin
      // line low: hold reset, period starts over on recovery
      next_r.state = st_reset;
      next_r.ticks = '0;
    end else begin
      case (r.state)
        st_reset: begin
          if (tick) begin
            next_r.ticks = r.ticks + tick_t'(1);
          end
          if (tick && r.ticks + tick_t'(1) >= limit) begin
            next_r.state = st_long;
            next_r.ticks = '0;
          end
        end
        st_long, st_short: begin
          if (r.float_sync[1]) begin
            next_r.ticks = '0;
          end else if (edge_seen) begin
            next_r.ticks = '0;
            next_r.state = st_short;
            next_r.watchdog_expired_n = 1'b1;
          end else if (tick) begin
            next_r.ticks = r.ticks + tick_t'(1);
            if (r.ticks + tick_t'(1) >= limit) begin
              // stuck toggle repeats reset after each long period
              next_r.state = st_reset;
              next_r.ticks = '0;
              next_r.watchdog_expired_n = 1'b0;
            end
          end
        end
        default: begin
          next_r.state = st_reset;
          next_r.ticks = '0;
        end
      endcase
    end
    if (!line_ok || bk) begin
      next_r.watchdog_expired_n = 1'b1;
    end
    next_r.reset_n       = (next_r.state != st_reset);
    next_r.reset         = !next_r.reset_n;
    next_r.under_n       = line_ok && !bk;
    next_r.backup_active = bk;
    next_r.early_warn_n  = r.warn_sync[1] && !bk;
    // one cycle of gating lag, traded for a registered output
    next_r.cs_out_n      = (line_ok && !bk) ? r.cs_sync[1] : 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r                    <= '0;
      r.state              <= st_reset;
      r.reset              <= 1'b1;
      r.watchdog_expired_n <= 1'b1;
      r.early_warn_n       <= 1'b1;
      r.cs_out_n           <= 1'b1;
      r.sel_sync           <= 2'b11;
      r.per_sync           <= 2'b11;
      r.cs_sync            <= 2'b11;
    end else begin
      r <= next_r;
    end
  end

  assign cpu_reset_n        = r.reset_n;
  assign cpu_reset          = r.reset;
  assign undervoltage_n     = r.under_n;
  assign backup_active      = r.backup_active;
  assign watchdog_expired_n = r.watchdog_expired_n;
  assign early_warn_n       = r.early_warn_n;
  assign cs_out_n           = r.cs_out_n;
endmodule : watchdog_reset_supervisor

// ### rtl/wd_supervisor_pkg.sv
// types for the watchdog reset supervisor
// assumes wd_supervisor_regs.svh supplies the counter widths
`include "wd_supervisor_regs.svh"
package wd_supervisor_pkg;
  typedef logic [`TICK_W-1:0] tick_t;
  typedef logic [`DIV_W-1:0]  div_t;
  typedef enum logic [1:0] {
    st_reset = 2'b00,
    st_long  = 2'b01,
    st_short = 2'b11
  } wd_state_e;
  typedef struct packed {
    logic [1:0] tb_sync;
    logic       tb_prev;
    logic [1:0] sel_sync;
    logic [1:0] per_sync;
    logic [1:0] tog_pin;
    logic [1:0] tog_sync;
    logic [1:0] cs_sync;
    logic [1:0] float_sync;
    logic [1:0] line_sync;
    logic [1:0] warn_sync;
    logic [1:0] bk_sync;
    logic       tog_seen;
    div_t       osc_div;
    logic       osc_clk;
    logic       osc_prev;
    wd_state_e  state;
    tick_t      ticks;
    logic       reset_n;
    logic       reset;
    logic       under_n;
    logic       backup_active;
    logic       watchdog_expired_n;
    logic       early_warn_n;
    logic       cs_out_n;
  } sup_s;
endpackage : wd_supervisor_pkg

// ### rtl/wd_supervisor_regs.svh
// timing constants and functional notes for the watchdog reset supervisor
// assumes clk runs at 20 MHz and comparator results arrive as logic levels
// Functional notes
// - reset pulse issued when toggle input idles for the full selected period.
// - right after any reset the long watchdog period applies.
// - watchdog counter restarts when the reset pulse ends, whatever caused it.
// - short period takes effect only after first toggle after reset release.
// - every rising or falling toggle edge restarts the timeout count.
// - a stuck toggle input yields a reset pulse after every long period.
// - floating or mid-supply toggle input disables watchdog monitoring.
// - external clock: 1024 normal, 4096 after reset, 512 reset width.
// - internal 10.24 kHz, period pin low: 100 ms, 1.6 s, 50 ms pulse.
// - internal timebase, period pin high: 1.6 s both normal and post-reset.
// - select high uses internal oscillator, select low uses timebase pin clock.
// - timeout status goes low on expiry, high again on first toggle edge after the reset pulse.
// - timeout status forced high while line sense is below threshold.
// - chip-select passes through while line sense is above threshold and backup is off.
// - chip-select output forced high while line sense is below threshold.
// - early warning output low while early-warning comparator reads low.
// - backup forces reset low, reset high, fixed levels on all other outputs.
// - backup ignores toggle, chip-select, timebase inputs; early warning disabled.
// - reset held while line low and for reset period after recovery.
// - active-high reset is always the complement of active-low reset.
// - undervoltage output follows the line-sense result outside backup; backup output follows the battery-backup input.
`ifndef WD_SUPERVISOR_REGS_SVH
`define WD_SUPERVISOR_REGS_SVH
`define CLK_HZ          20000000
`define OSC_HZ          10240
`define OSC_DIV         ((`CLK_HZ / `OSC_HZ) / 2)
`define EXT_NORMAL_TKS  1024
`define EXT_LONG_TKS    4096
`define EXT_RESET_TKS   512
`define INT_SHORT_MS    100
`define INT_LONG_MS     1600
`define INT_RESET_MS    50
`define INT_SHORT_TKS   ((`INT_SHORT_MS * `OSC_HZ) / 1000)
`define INT_LONG_TKS    ((`INT_LONG_MS * `OSC_HZ) / 1000)
`define INT_RESET_TKS   ((`INT_RESET_MS * `OSC_HZ) / 1000)
`define TICK_W          16
`define DIV_W           11
`endif

// ### tb/processor_model.sv
// processor and external oscillator on the far side of the watchdog
// assumes clk from the bench; oscillator runs free, phase unrelated
module processor_model (
  input  wire logic clk,
  input  wire logic kick_on,
  output logic      timebase_in,
  output logic      watchdog_toggle_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial begin
    timebase_in = 1'b0;
    #13;
    forever #100 timebase_in = ~timebase_in;
  end
  initial watchdog_toggle_in = 1'b0;
  // edges 50 ticks apart, far inside the short period
  always @(negedge clk) begin
    n <= kick_on ? n + 1 : 0;
    if (kick_on && n % 200 == 199) watchdog_toggle_in <= ~watchdog_toggle_in;
  end
endmodule : processor_model

// ### tb/supervisor_properties.sv
// port checker for the watchdog reset supervisor
// assumes a bind from the bench top file; all inputs are async levels
module supervisor_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic line_sense,
  input wire logic early_warn_in,
  input wire logic battery_backup,
  input wire logic cs_in_n,
  input wire logic cpu_reset_n,
  input wire logic cpu_reset,
  input wire logic undervoltage_n,
  input wire logic backup_active,
  input wire logic watchdog_expired_n,
  input wire logic early_warn_n,
  input wire logic cs_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // 3-clock sync latency, so levels must hold a few cycles first
  property p_pair; cpu_reset == !cpu_reset_n; endproperty
  property p_pass; (line_sense && !battery_backup)[*5] |-> cs_out_n == $past(cs_in_n, 3);
  endproperty
  property p_gate; !line_sense[*4] |-> cs_out_n; endproperty
  property p_flag; !line_sense[*4] |-> watchdog_expired_n; endproperty
  property p_low; !line_sense[*4] |-> !cpu_reset_n && !undervoltage_n; endproperty
  property p_uv; (line_sense && !battery_backup)[*4] |-> undervoltage_n; endproperty
  property p_warn; (!early_warn_in && !battery_backup)[*4] |-> !early_warn_n; endproperty
  property p_bk; battery_backup[*4] |-> !cpu_reset_n && backup_active && cs_out_n
    && watchdog_expired_n && !early_warn_n && !undervoltage_n; endproperty
  property p_exp; $fell(watchdog_expired_n) |-> ##[0:4] !cpu_reset_n; endproperty
  a_pair: assert property (p_pair) else $error("reset pair differs");
  a_pass: assert property (p_pass) else $error("cs not passed");
  a_gate: assert property (p_gate) else $error("cs not gated");
  a_flag: assert property (p_flag) else $error("timeout flag low");
  a_low: assert property (p_low) else $error("no low line reset");
  a_uv: assert property (p_uv) else $error("undervoltage wrong");
  a_warn: assert property (p_warn) else $error("no early warning");
  a_bk: assert property (p_bk) else $error("backup levels wrong");
  a_exp: assert property (p_exp) else $error("expiry without reset");
  c_exp: cover property ($fell(watchdog_expired_n));
  c_bk: cover property ($rose(backup_active));
  c_rst: cover property ($rose(cpu_reset_n));
endmodule : supervisor_properties

// ### tb/testbench.sv
// self-checking bench for the watchdog reset supervisor
// assumes external timebase of 4 clocks per tick to keep runs short
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, toggle_floating, timebase_select, line_sense, early_warn_in;
  logic battery_backup, cs_in_n, kick_on, timebase_in, watchdog_toggle_in;
  logic cpu_reset_n, cpu_reset, undervoltage_n, backup_active;
  logic watchdog_expired_n, early_warn_n, cs_out_n;
  int failures = 0, comparisons = 0, cycles = 0, n;
  watchdog_reset_supervisor dut (.clk(clk), .reset_n(reset_n),
    .watchdog_toggle_in(watchdog_toggle_in), .toggle_floating(toggle_floating),
    .timebase_select(timebase_select), .timebase_in(timebase_in), .line_sense(line_sense),
    .early_warn_in(early_warn_in), .battery_backup(battery_backup), .cs_in_n(cs_in_n),
    .cpu_reset_n(cpu_reset_n), .cpu_reset(cpu_reset), .undervoltage_n(undervoltage_n),
    .backup_active(backup_active), .watchdog_expired_n(watchdog_expired_n),
    .early_warn_n(early_warn_n), .cs_out_n(cs_out_n));
  processor_model cpu (.clk(clk), .kick_on(kick_on), .timebase_in(timebase_in),
    .watchdog_toggle_in(watchdog_toggle_in));
  task automatic check(input logic got, input string what);
    comparisons++;
    if (got !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask : check
  task automatic until_lvl(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 40000) begin
      @(negedge clk);
      c++;
    end
  endtask : until_lvl
  // counts cycles with reset asserted over a window
  task automatic quiet(input int len, output int c);
    c = 0;
    repeat (len) begin
      @(negedge clk);
      if (cpu_reset_n !== 1'b1) c++;
    end
  endtask : quiet
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic power_test();
    cs_in_n = 1'b0;
    repeat (6) @(negedge clk);
    check(cs_out_n === 1'b1, "cs not gated");
    check(watchdog_expired_n === 1'b1, "flag low at low line");
    check(cpu_reset_n === 1'b0 && cpu_reset === 1'b1, "no low line reset");
    line_sense = 1'b1;
    until_lvl(cpu_reset_n, 1'b1, n);
    check(n >= 2040 && n <= 2120, "reset width");
    check(cs_out_n === 1'b0, "cs not passed");
    $display("power test done");
  endtask : power_test
  task automatic watchdog_test();
    kick_on = 1'b1;
    quiet(20000, n);
    check(n == 0, "reset despite toggles");
    @(watchdog_toggle_in);
    kick_on = 1'b0;
    until_lvl(watchdog_expired_n, 1'b0, n);
    check(n >= 4090 && n <= 4130, "short period");
    check(cpu_reset_n === 1'b0, "expiry without reset");
    until_lvl(cpu_reset_n, 1'b1, n);
    check(n >= 2030 && n <= 2070, "expiry reset width");
    until_lvl(cpu_reset_n, 1'b0, n);
    check(n >= 16370 && n <= 16420, "long period after reset");
    check(watchdog_expired_n === 1'b0, "flag not held");
    kick_on = 1'b1;
    until_lvl(watchdog_expired_n, 1'b1, n);
    check(n <= 2400, "flag not cleared by toggle");
    $display("watchdog test done");
  endtask : watchdog_test
  task automatic backup_test();
    {kick_on, toggle_floating, early_warn_in} = 3'h2;
    quiet(20000, n);
    check(n == 0, "watchdog not disabled");
    repeat (2) @(negedge clk);
    check(early_warn_n === 1'b0, "no early warning");
    {battery_backup, timebase_select, early_warn_in} = 3'h7;
    repeat (6) @(negedge clk);
    check({cpu_reset_n, undervoltage_n, backup_active, watchdog_expired_n,
      early_warn_n, cs_out_n} === 6'h0d, "backup levels");
    $display("backup test done");
  endtask : backup_test
  initial begin
    {toggle_floating, timebase_select, line_sense, battery_backup, kick_on} = 5'h00;
    {early_warn_in, cs_in_n, reset_n} = 3'h6;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    power_test();
    watchdog_test();
    backup_test();
    give_verdict();
  end
endmodule : testbench
bind watchdog_reset_supervisor supervisor_properties chk (.*);
